// *** rtl/lfs_supervisor.sv ***
// How it works
// - Enable low beyond the sleep delay enters sleep and shuts everything down except the phased clock output in external mode.
// - Sleep delay is 32,768 oscillator periods, scaling with oscillator frequency.
// - Gate is off while enable is low; high again resumes switching.
// - Oscillator runs internal, resistor-set or external, 100 to 700 kHz.
// - osc_mode other than resistor-set or external selects internal 350 kHz; the timing pin only clocks external mode.
// - Phased clock output runs at oscillator rate, delayed in phase.
// - Any fault releases one or both flags until removed or cleared.
// - Flags pull low for no fault and float for a fault.
// - Undervoltage, shorts and open LED force the gate low, per flag table.
// - Undercurrent, overtemperature, single short release general flag only, keep switching.
// - Output and string shorts stay latched until sleep or power cycle.
// - Open LED is latched, cleared by enable low, the open fault timeout or power cycle.
// - Fault detectors other than open LED are ignored during the blanking interval after start-up, though undervoltage still holds the gate low.
// - Open LED detection is never blanked and stops the gate immediately.
// - Undervoltage holds gate low, releases both flags, not latched.
// - Undercurrent releases general flag, clears as soon as indication clears.
// - Overtemperature releases general flag only, no limiting action.
// - Flag held low externally overrides the matching short or open LED gate disable, not the undervoltage one.
// - Open LED disable retries the gate after the open fault timeout.
`timescale 1ns/1ps
`default_nettype none

module lfs_supervisor
   import lfs_pkg::*;
#(
   parameter int unsigned SLEEP_TICKS = SLEEP_RATIO,
   parameter int unsigned BLANK_TICKS = BLANK_RATIO,
   parameter int unsigned OPEN_TICKS  = OPEN_RATIO
) (
   // Clock and reset.
   input  wire logic                 clock,
   input  wire logic                 rst,
   // Host enable pin.
   input  wire logic                 enable,
   // Oscillator source and timing.
   input  wire logic [1:0]           osc_mode,
   input  wire logic [OSC_PER_W-1:0] osc_res_period,
   input  wire logic                 timing_pin,
   output logic                      phased_clock_output,
   // Fault detector outputs.
   input  wire logic                 uv_det,
   input  wire logic                 out_short_det,
   input  wire logic                 string_short_det,
   input  wire logic                 open_led_det,
   input  wire logic                 under_current_det,
   input  wire logic                 over_temp_det,
   input  wire logic                 led_short_det,
   // Converter switching request and gate drive.
   input  wire logic                 switch_req,
   output logic                      gate_drive_output,
   output logic                      sleep_state,
   // Open-drain critical fault flag.
   input  wire logic                 critical_fault_flag_i,
   output logic                      critical_fault_flag_o,
   output logic                      critical_fault_flag_oe_n,
   // Open-drain general fault flag.
   input  wire logic                 general_fault_flag_i,
   output logic                      general_fault_flag_o,
   output logic                      general_fault_flag_oe_n
);

   localparam int SLW = $clog2(SLEEP_TICKS + 1);
   localparam int BLW = $clog2(BLANK_TICKS + 1);
   localparam int OPW = $clog2(OPEN_TICKS + 1);

   logic [SYNC_W-1:0]    sync1_r;
   logic [SYNC_W-1:0]    sync2_r;
   logic                 en_s, uv_s, osh_s, ssh_s, open_s, uc_s, ot_s, lsh_s;
   logic                 tpin_s, crit_in_s, gen_in_s;
   lfs_osc_mode_t        mode_s;
   logic [OSC_PER_W-1:0] res_s;
   logic [OSC_PER_W-1:0] period;
   logic [OSC_PER_W-1:0] per_cnt_r;
   logic                 tpin_d_r;
   logic                 osc_lvl, osc_tick;
   logic [PHASE_CYC-1:0] phase_r;
   logic [SLW-1:0]       sleep_cnt_r;
   logic                 sleep_r;
   logic [BLW-1:0]       blank_cnt_r;
   logic                 blank_done;
   logic                 short_lat_r, open_lat_r;
   logic [OPW-1:0]       open_cnt_r;
   logic                 open_expire;
   logic                 uv_act, crit_rel, gen_rel;
   logic                 crit_ovr, gen_ovr, gate_en;
   logic [3:0]           rel_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.

   // Every pin and detector input except switch_req passes two flip-flops before use.
   always_ff @(posedge clock) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {enable, uv_det, out_short_det, string_short_det, open_led_det,
                     under_current_det, over_temp_det, led_short_det, timing_pin,
                     critical_fault_flag_i, general_fault_flag_i, osc_mode,
                     osc_res_period};
         sync2_r <= sync1_r;
      end
   end

   // Unpack the synchronised vector.
   assign {en_s, uv_s, osh_s, ssh_s, open_s, uc_s, ot_s, lsh_s, tpin_s,
           crit_in_s, gen_in_s} = sync2_r[SYNC_W-1 -: 11];
   assign mode_s = lfs_osc_mode_t'(sync2_r[OSC_PER_W +: 2]);
   assign res_s  = sync2_r[OSC_PER_W-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator.

   // Internal source unless the resistor-set mode gives a clamped period.
   always_comb begin
      period = OSC_PER_W'(OSC_INT_CYC);
      if (mode_s == LFS_OSC_RES) begin
         if (res_s < OSC_PER_W'(OSC_MIN_CYC)) begin
            period = OSC_PER_W'(OSC_MIN_CYC);
         end else if (res_s > OSC_PER_W'(OSC_MAX_CYC)) begin
            period = OSC_PER_W'(OSC_MAX_CYC);
         end else begin
            period = res_s;
         end
      end
   end

   // Period counter for the internal and resistor-set sources.
   always_ff @(posedge clock) begin
      if (rst || sleep_r || per_cnt_r >= period - 1'b1) begin
         per_cnt_r <= '0;
      end else begin
         per_cnt_r <= per_cnt_r + 1'b1;
      end
   end

   // Delayed copy of the external clock for its rising edge.
   always_ff @(posedge clock) begin
      if (rst) begin
         tpin_d_r <= RST_LOW;
      end else begin
         tpin_d_r <= tpin_s;
      end
   end

   // One tick per oscillator period from the selected source.
   always_comb begin
      if (mode_s == LFS_OSC_EXT) begin
         osc_tick = tpin_s & ~tpin_d_r;
         osc_lvl  = tpin_s;
      end else begin
         osc_tick = (per_cnt_r == period - 1'b1) & ~sleep_r;
         osc_lvl  = (per_cnt_r < (period >> 1)) & ~sleep_r;
      end
   end

   // Phased clock output is the oscillator level shifted by a fixed delay.
   always_ff @(posedge clock) begin
      if (rst) begin
         phase_r <= '0;
      end else begin
         phase_r <= {phase_r[PHASE_CYC-2:0], osc_lvl};
      end
   end
   assign phased_clock_output = phase_r[PHASE_CYC-1];

   ////////////////////////////////////////////////////////////////////////////
   // Sleep timing.

   // Count oscillator periods while enable is low; expiry enters sleep.
   always_ff @(posedge clock) begin
      if (rst || en_s) begin
         sleep_cnt_r <= '0;
      end else if (!sleep_r && osc_tick) begin
         sleep_cnt_r <= sleep_cnt_r + 1'b1;
      end
   end

   // Sleep holds until enable returns high.
   always_ff @(posedge clock) begin
      if (rst || en_s) begin
         sleep_r <= RST_LOW;
      end else if (osc_tick && sleep_cnt_r == SLW'(SLEEP_TICKS - 1)) begin
         sleep_r <= RST_HIGH;
      end
   end
   assign sleep_state = sleep_r;

   ////////////////////////////////////////////////////////////////////////////
   // Fault blanking.

   // Blanking runs from reset or sleep exit; sleep restarts it.
   always_ff @(posedge clock) begin
      if (rst || sleep_r) begin
         blank_cnt_r <= '0;
      end else if (osc_tick && !blank_done) begin
         blank_cnt_r <= blank_cnt_r + 1'b1;
      end
   end
   assign blank_done = (blank_cnt_r == BLW'(BLANK_TICKS));

   ////////////////////////////////////////////////////////////////////////////
   // Fault latches.

   // Output and string shorts latch after blanking; only sleep clears them.
   always_ff @(posedge clock) begin
      if (rst) begin
         short_lat_r <= RST_LOW;
      end else if (blank_done && (osh_s || ssh_s)) begin
         short_lat_r <= RST_HIGH;
      end else if (sleep_r) begin
         short_lat_r <= RST_LOW;
      end
   end

   // Open LED latches unblanked; enable low or the timeout clears it for a two-cycle retry.
   always_ff @(posedge clock) begin
      if (rst) begin
         open_lat_r <= RST_LOW;
      end else if (open_s && en_s && !sleep_r && !open_expire) begin
         open_lat_r <= RST_HIGH;
      end else if (!en_s || open_expire) begin
         open_lat_r <= RST_LOW;
      end
   end

   // Open fault timeout counts oscillator periods while the latch is set.
   always_ff @(posedge clock) begin
      if (rst || !open_lat_r || sleep_r) begin
         open_cnt_r <= '0;
      end else if (osc_tick && !open_expire) begin
         open_cnt_r <= open_cnt_r + 1'b1;
      end
   end
   assign open_expire = (open_cnt_r == OPW'(OPEN_TICKS));

   ////////////////////////////////////////////////////////////////////////////
   // Flags and gate.

   // Flag releases per fault class.
   assign uv_act   = uv_s & blank_done;
   assign crit_rel = uv_act | short_lat_r;
   assign gen_rel  = uv_act | open_lat_r | (blank_done & (uc_s | ot_s | lsh_s));

   // An external party holding a released flag low overrides its latch disable, not undervoltage.
   assign crit_ovr = short_lat_r & rel_d_r[3] & ~crit_in_s;
   assign gen_ovr  = open_lat_r & rel_d_r[1] & ~gen_in_s;

   // Gate permission: enable, awake, no undervoltage, no unoverridden latch.
   assign gate_en = en_s & ~sleep_r & ~uv_s
                  & ~(short_lat_r & ~crit_ovr) & ~(open_lat_r & ~gen_ovr);

   // Registered gate drive follows the converter's switching request.
   always_ff @(posedge clock) begin
      if (rst) begin
         gate_drive_output <= RST_LOW;
      end else begin
         gate_drive_output <= gate_en & switch_req;
      end
   end

   // Open-drain flags; for the override the critical and the general release are both delayed two cycles to match the pin synchroniser.
   always_ff @(posedge clock) begin
      if (rst) begin
         critical_fault_flag_oe_n <= RST_LOW;
         general_fault_flag_oe_n  <= RST_LOW;
         rel_d_r                  <= '0;
      end else begin
         critical_fault_flag_oe_n <= crit_rel & ~sleep_r;
         general_fault_flag_oe_n  <= gen_rel & ~sleep_r;
         rel_d_r <= {rel_d_r[2], critical_fault_flag_oe_n, rel_d_r[0], general_fault_flag_oe_n};
      end
   end
   assign critical_fault_flag_o = RST_LOW;
   assign general_fault_flag_o  = RST_LOW;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   sequence s_low_expire;
      !en_s && osc_tick && sleep_cnt_r == SLW'(SLEEP_TICKS - 1);
   endsequence
   property p_sleep_entry;
      @(posedge clock) disable iff (rst) s_low_expire ##1 !en_s |-> sleep_r;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
   property p_sleep_cause;
      @(posedge clock) disable iff (rst)
         $rose(sleep_r) |-> $past(sleep_cnt_r) == SLW'(SLEEP_TICKS - 1);
   endproperty
   a_sleep_cause: assert property (p_sleep_cause) else $error("early sleep");
   property p_en_low_gate;
      @(posedge clock) disable iff (rst) !en_s |=> !gate_drive_output;
   endproperty
   a_en_low_gate: assert property (p_en_low_gate) else $error("gate on, enable low");
   property p_uv_flags;
      @(posedge clock) disable iff (rst)
         uv_s && blank_done && !sleep_r |=> critical_fault_flag_oe_n && general_fault_flag_oe_n
                                            && !gate_drive_output;
   endproperty
   a_uv_flags: assert property (p_uv_flags) else $error("undervoltage response");
   property p_short_hold;
      @(posedge clock) disable iff (rst) short_lat_r && !sleep_r |=> short_lat_r;
   endproperty
   a_short_hold: assert property (p_short_hold) else $error("short latch lost");
   property p_short_gate;
      @(posedge clock) disable iff (rst) $rose(short_lat_r) && !crit_ovr |=> !gate_drive_output;
   endproperty
   a_short_gate: assert property (p_short_gate) else $error("short gate on");
   property p_short_blank;
      @(posedge clock) disable iff (rst) $rose(short_lat_r) |-> $past(blank_done);
   endproperty
   a_short_blank: assert property (p_short_blank) else $error("short during blank");
   sequence s_open_seen;
      open_s && en_s && !sleep_r && !open_lat_r;
   endsequence
   property p_open_gate;
      @(posedge clock) disable iff (rst)
         s_open_seen ##1 (open_lat_r && !gen_ovr) |=> !gate_drive_output;
   endproperty
   a_open_gate: assert property (p_open_gate) else $error("open LED gate on");
   property p_uc_flag;
      @(posedge clock) disable iff (rst)
         uc_s && blank_done && !sleep_r && !uv_s && !short_lat_r |=> general_fault_flag_oe_n
                                                   && !critical_fault_flag_oe_n;
   endproperty
   a_uc_flag: assert property (p_uc_flag) else $error("undercurrent flag");
   property p_no_fault;
      @(posedge clock) disable iff (rst)
         !crit_rel && !gen_rel |=> !critical_fault_flag_oe_n && !general_fault_flag_oe_n;
   endproperty
   a_no_fault: assert property (p_no_fault) else $error("flag released, no fault");

endmodule // lfs_supervisor

`default_nettype wire

// *** inc/lfs_pkg.sv ***
`default_nettype none

package lfs_pkg;

   // System clock rate and the oscillator figures, in kHz.
   localparam int unsigned CLK_KHZ     = 100000;
   localparam int unsigned OSC_INT_KHZ = 350;
   localparam int unsigned OSC_MIN_KHZ = 100;
   localparam int unsigned OSC_MAX_KHZ = 700;

   // Oscillator periods in system clock cycles.
   localparam int unsigned OSC_INT_CYC = CLK_KHZ / OSC_INT_KHZ;
   localparam int unsigned OSC_MIN_CYC = (CLK_KHZ + OSC_MAX_KHZ - 1) / OSC_MAX_KHZ;
   localparam int unsigned OSC_MAX_CYC = CLK_KHZ / OSC_MIN_KHZ;
   localparam int unsigned OSC_PER_W   = 10;

   // Sleep entry delay as a count of oscillator periods.
   localparam int unsigned SLEEP_RATIO = 32768;

   // Fault blanking and open fault timeout, in oscillator periods.
   localparam int unsigned BLANK_RATIO = 1024;
   localparam int unsigned OPEN_RATIO  = 4096;

   // Delay of the phased clock output, in system clock cycles.
   localparam int unsigned PHASE_CYC = 64;

   // Number of asynchronous input bits passed through the synchroniser.
   localparam int unsigned SYNC_W = 13 + OSC_PER_W;

   // Reset values.
   localparam logic RST_LOW  = 1'b0;
   localparam logic RST_HIGH = 1'b1;

   // Oscillator source selection.
   typedef enum logic [1:0] {
      LFS_OSC_INT,
      LFS_OSC_RES,
      LFS_OSC_EXT
   } lfs_osc_mode_t;

endpackage : lfs_pkg

`default_nettype wire

// *** verif/lfs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Host side of the two open-drain fault lines, with pull-ups and a way to sink them.
module lfs_host_model (
   // Design drivers of the two lines.
   input  wire logic crit_drv,
   input  wire logic crit_rel_n,
   input  wire logic gen_drv,
   input  wire logic gen_rel_n,
   // Commands that make the host sink a line.
   input  wire logic hold_crit,
   input  wire logic hold_gen,
   // Resolved line levels.
   output logic      crit_pin,
   output logic      gen_pin
);
   // A released line floats up to its pull-up unless the host sinks it.
   assign crit_pin = !((!crit_rel_n && !crit_drv) || hold_crit);
   assign gen_pin  = !((!gen_rel_n && !gen_drv) || hold_gen);
endmodule // lfs_host_model

`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

// Compares one design value with its expectation and counts the outcome.
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end

module tb;
   import lfs_pkg::*;
   localparam int RES = 143;
   logic                 clock, rst, enable, timing_pin, switch_req, pv;
   logic [1:0]           osc_mode;
   logic [OSC_PER_W-1:0] res_per;
   logic                 uv, osh, ssh, opn, uc, ot, lsh, hold_crit, hold_gen;
   wire logic            gate, slp, phased, crit_pin, gen_pin, crit_o, crit_oe_n, gen_o, gen_oe_n;
   int                   mismatches, n_checks, cnt;

   ////////////////////////////////////////////////////////////////
   // Shortened timers keep every wait to a few thousand cycles.
   lfs_supervisor #(.SLEEP_TICKS(8), .BLANK_TICKS(4), .OPEN_TICKS(4)) lfs_supervisor_i (
      .clock(clock), .rst(rst), .enable(enable), .osc_mode(osc_mode),
      .osc_res_period(res_per), .timing_pin(timing_pin), .phased_clock_output(phased),
      .uv_det(uv), .out_short_det(osh), .string_short_det(ssh), .open_led_det(opn),
      .under_current_det(uc), .over_temp_det(ot), .led_short_det(lsh),
      .switch_req(switch_req), .gate_drive_output(gate), .sleep_state(slp),
      .critical_fault_flag_i(crit_pin), .critical_fault_flag_o(crit_o),
      .critical_fault_flag_oe_n(crit_oe_n), .general_fault_flag_i(gen_pin),
      .general_fault_flag_o(gen_o), .general_fault_flag_oe_n(gen_oe_n));

   // The host holds pull-ups on both fault lines.
   lfs_host_model lfs_host_model_i (
      .crit_drv(crit_o), .crit_rel_n(crit_oe_n), .gen_drv(gen_o), .gen_rel_n(gen_oe_n),
      .hold_crit(hold_crit), .hold_gen(hold_gen), .crit_pin(crit_pin), .gen_pin(gen_pin));

   ////////////////////////////////////////////////////////////////
   // Clock at 100 MHz and an external oscillator of 150 cycles per period.
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   initial forever begin
      repeat (75) @(posedge clock);
      #1 timing_pin = ~timing_pin;
   end

   // Advances a number of edges and lands just after the last one.
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // Polls the gate each cycle until it shows the wanted level.
   task automatic wait_gate(input logic v, input int lim);
      for (cnt = 0; cnt < lim && gate !== v; cnt++) step(1);
   endtask

   // Holds reset for five cycles, then checks the idle outputs.
   task automatic t_reset;
      rst = 1'h1;
      step(5);
      rst = 1'h0;
      `CHK("gate", 1'h0, gate)
      `CHK("crit", 1'h0, crit_oe_n)
      `CHK("gen", 1'h0, gen_oe_n)
      `CHK("crit drv", 1'h0, crit_o)
      `CHK("gen drv", 1'h0, gen_o)
      osh = 1'h1;
      step(10);
      `CHK("blank crit", 1'h0, crit_oe_n)
      `CHK("blank gate", 1'h1, gate)
      osh = 1'h0;
      step(6 * RES);
   endtask

   // Dims with a period well below the sleep delay.
   task automatic t_pwm;
      repeat (3) begin
         enable = 1'h0;
         step(4);
         `CHK("pwm gate", 1'h0, gate)
         step(200);
         enable = 1'h1;
         step(4);
         `CHK("pwm gate", 1'h1, gate)
         step(200);
      end
      `CHK("sleep", 1'h0, slp)
   endtask

   // Undercurrent, overtemperature and single short each raise the general line only.
   task automatic t_warn;
      for (int k = 0; k < 3; k++) begin
         {uc, ot, lsh} = 3'h4 >> k;
         step(4);
         `CHK("gen", 1'h1, gen_oe_n)
         `CHK("gen pin", 1'h1, gen_pin)
         `CHK("crit", 1'h0, crit_oe_n)
         `CHK("gate", 1'h1, gate)
         {uc, ot, lsh} = 3'h0;
         step(4);
         `CHK("gen", 1'h0, gen_oe_n)
      end
      uv = 1'h1;
      step(4);
      `CHK("uv gate", 1'h0, gate)
      `CHK("uv crit", 1'h1, crit_oe_n)
      `CHK("uv gen", 1'h1, gen_oe_n)
      uv = 1'h0;
      step(4);
      `CHK("uv gate", 1'h1, gate)
   endtask

   // Output short and string short latch until sleep clears them.
   task automatic t_short;
      for (int k = 0; k < 2; k++) begin
         {osh, ssh} = 2'h2 >> k;
         step(5);
         `CHK("gate", 1'h0, gate)
         `CHK("crit", 1'h1, crit_oe_n)
         `CHK("crit pin", 1'h1, crit_pin)
         `CHK("gen", 1'h0, gen_oe_n)
         {osh, ssh} = 2'h0;
         hold_crit = 1'h1;
         step(5);
         `CHK("override", 1'h1, gate)
         hold_crit = 1'h0;
         enable = 1'h0;
         step(50);
         enable = 1'h1;
         step(5);
         `CHK("latched", 1'h0, gate)
         enable = 1'h0;
         for (cnt = 0; cnt < 12 * RES && slp !== 1'h1; cnt++) step(1);
         enable = 1'h1;
         step(5);
         `CHK("cleared", 1'h0, crit_oe_n)
         step(6 * RES);
      end
   endtask

   // Times the sleep delay for one oscillator source and its period.
   task automatic t_sleep(input logic [1:0] m, input int p);
      osc_mode = m;
      step(2 * p);
      if (m == 2'h2) begin
         cnt = 0;
         pv = phased;
         repeat (1500) begin
            step(1);
            if (phased === 1'h1 && pv === 1'h0) cnt++;
            pv = phased;
         end
         `CHK("phased edges", 1'h1, (cnt >= 9 && cnt <= 11))
      end
      enable = 1'h0;
      for (cnt = 0; cnt < 12 * p && slp !== 1'h1; cnt++) step(1);
      `CHK("sleep delay", 1'h1, (cnt >= 7 * p && cnt <= 9 * p + 10))
      `CHK("sleep gate", 1'h0, gate)
      enable = 1'h1;
      step(4);
      `CHK("awake", 1'h0, slp)
      step(6 * p);
   endtask

   // Open LED, raised after blanking has ended, stops the gate and retries after the timeout.
   task automatic t_open;
      osc_mode = 2'h1;
      t_reset;
      opn = 1'h1;
      step(5);
      `CHK("open gate", 1'h0, gate)
      `CHK("open gen", 1'h1, gen_oe_n)
      hold_gen = 1'h1;
      step(5);
      `CHK("override", 1'h1, gate)
      hold_gen = 1'h0;
      opn = 1'h0;
      step(5);
      `CHK("latched", 1'h0, gate)
      wait_gate(1'h1, 6 * RES);
      `CHK("retry", 1'h1, gate)
      opn = 1'h1;
      step(5);
      wait_gate(1'h1, 6 * RES);
      `CHK("retry", 1'h1, gate)
      step(5);
      `CHK("relatch", 1'h0, gate)
      enable = 1'h0;
      opn = 1'h0;
      step(5);
      enable = 1'h1;
      step(5);
      `CHK("cleared", 1'h0, gen_oe_n)
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (60000) @(posedge clock);
      mismatches++;
      wrap_up;
   end

   // Main sequence of scenarios.
   initial begin
      {mismatches, n_checks} = '0;
      {rst, enable, switch_req} = 3'h7;
      {timing_pin, hold_crit, hold_gen} = 3'h0;
      {uv, osh, ssh, opn, uc, ot, lsh} = 7'h00;
      osc_mode = 2'h1;
      res_per = 10'h08F;
      t_reset;
      t_pwm;
      t_warn;
      t_short;
      t_sleep(2'h0, 285);
      t_sleep(2'h3, 285);
      t_sleep(2'h2, 150);
      t_sleep(2'h1, RES);
      t_open;
      wrap_up;
   end
endmodule // tb

`default_nettype wire
